// >>> logic/bya_alu_top.sv
// Purpose: 8-bit execution datapath for five byte instructions, APB programmed
// Assumes: APB3 master, one clock, file registers held in bya_file_mem
// Notes: Any APB access waits while an operation runs
// Behaviour
// - Subtract-with-borrow: file minus accumulator minus inverted borrow, to dest.
// - Nibble exchange swaps file nibbles, flags untouched, result to dest.
// - Direction load copies accumulator to port A/B/C for operand 5/6/7.
// - XOR literal: accumulator xor immediate into accumulator, null flag only.
// - XOR file: accumulator xor file register to dest, null flag only.
// - Borrow and nibble borrow flags are one when no borrow occurs.
`timescale 1ns/100ps
`include "bya_regs.svh"
module bya_alu_top import bya_pkg::*; #(
  parameter int FILE_AW = 7
) (
  input wire logic clock, // 250 MHz core clock
  input wire logic rstn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error on unmapped address
  output logic [7:0] portADirection, // Port A direction
  output logic [7:0] portBDirection, // Port B direction
  output logic [7:0] portCDirection // Port C direction
);
  bya_mem_if #(.AW(FILE_AW), .DW(8)) memBus ();

  bya_file_mem #(.AW(FILE_AW), .DW(8)) u_mem (
    .clock(clock),
    .rstn(rstn),
    .bus(memBus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  bya_state_e state_ff, nxt_state;
  bya_op_e cmdOp_ff, nxt_cmdOp;
  logic cmdDest_ff, nxt_cmdDest;
  logic [6:0] cmdAddr_ff, nxt_cmdAddr;
  bya_byte_t cmdLit_ff, nxt_cmdLit;
  bya_byte_t acc_ff, nxt_acc;
  logic borrowOutFlag_ff, nxt_borrowOutFlag;
  logic nibbleBorrowFlag_ff, nxt_nibbleBorrowFlag;
  logic resultNullFlag_ff, nxt_resultNullFlag;
  logic badOp_ff, nxt_badOp;
  bya_byte_t dirA_ff, nxt_dirA;
  bya_byte_t dirB_ff, nxt_dirB;
  bya_byte_t dirC_ff, nxt_dirC;
  logic [1:0] rdStep_ff, nxt_rdStep;
  logic [31:0] prdata_ff, nxt_prdata;

  logic busy;
  logic access;
  logic isFile;
  logic regHit;
  logic wrFire;
  bya_byte_t fileVal;
  bya_byte_t result;
  logic [8:0] diff;
  logic [4:0] diffLow;
  logic [31:0] regRead;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  always_comb begin
    busy = (state_ff != ST_IDLE);
    access = psel && penable;
    isFile = (paddr[11:9] == `BYA_FILE_SEL);
    regHit = (paddr == `BYA_OFF_CMD) || (paddr == `BYA_OFF_ACC) ||
             (paddr == `BYA_OFF_STAT) || (paddr == `BYA_OFF_DIR);
    // Reads need a memory cycle and a capture cycle, so they all take three
    pready = !busy && (pwrite || (rdStep_ff == `BYA_RD_STEPS));
    pslverr = access && pready && !(regHit || isFile);
    wrFire = access && pwrite && pready;
  end

  always_comb begin
    regRead = 32'h0000_0000;
    case (paddr)
      `BYA_OFF_CMD: begin
        regRead[`BYA_CMD_OP_LSB +: 3] = cmdOp_ff;
        regRead[`BYA_CMD_DEST_BIT] = cmdDest_ff;
        regRead[`BYA_CMD_ADDR_LSB +: 7] = cmdAddr_ff;
        regRead[`BYA_CMD_LIT_LSB +: 8] = cmdLit_ff;
      end
      `BYA_OFF_ACC: begin
        regRead[7:0] = acc_ff;
      end
      `BYA_OFF_STAT: begin
        regRead[`BYA_ST_BORROW] = borrowOutFlag_ff;
        regRead[`BYA_ST_NIBBLE] = nibbleBorrowFlag_ff;
        regRead[`BYA_ST_NULL] = resultNullFlag_ff;
        regRead[`BYA_ST_BUSY] = busy;
        regRead[`BYA_ST_BADOP] = badOp_ff;
      end
      `BYA_OFF_DIR: begin
        regRead[23:0] = {dirC_ff, dirB_ff, dirA_ff};
      end
      default: begin
        regRead = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath
  always_comb begin
    fileVal = memBus.rdata;
    diff = {1'b0, fileVal} - {1'b0, acc_ff} - {8'h00, ~borrowOutFlag_ff};
    diffLow = {1'b0, fileVal[3:0]} - {1'b0, acc_ff[3:0]} - {4'h0, ~borrowOutFlag_ff};
    case (cmdOp_ff)
      OP_SUB_WITH_BORROW: result = diff[7:0];
      OP_NIBBLE_EXCHANGE: result = {fileVal[3:0], fileVal[7:4]};
      OP_XOR_LITERAL: result = acc_ff ^ cmdLit_ff;
      OP_XOR_FILE: result = acc_ff ^ fileVal;
      default: result = acc_ff;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    nxt_state = state_ff;
    nxt_cmdOp = cmdOp_ff;
    nxt_cmdDest = cmdDest_ff;
    nxt_cmdAddr = cmdAddr_ff;
    nxt_cmdLit = cmdLit_ff;
    nxt_acc = acc_ff;
    nxt_borrowOutFlag = borrowOutFlag_ff;
    nxt_nibbleBorrowFlag = nibbleBorrowFlag_ff;
    nxt_resultNullFlag = resultNullFlag_ff;
    nxt_badOp = badOp_ff;
    nxt_dirA = dirA_ff;
    nxt_dirB = dirB_ff;
    nxt_dirC = dirC_ff;
    nxt_rdStep = 2'h0;
    nxt_prdata = prdata_ff;
    memBus.we = 1'b0;
    memBus.addr = paddr[FILE_AW+1:2];
    memBus.wdata = pwdata[7:0];
    case (state_ff)
      ST_IDLE: begin
        if (access && !pwrite && !pready) begin
          nxt_rdStep = rdStep_ff + 2'h1;
        end
        if (access && !pwrite && (rdStep_ff == 2'h1)) begin
          nxt_prdata = isFile ? {24'h00_0000, fileVal} : regRead;
        end
        if (wrFire && isFile) begin
          memBus.we = 1'b1;
        end
        if (wrFire && (paddr == `BYA_OFF_CMD)) begin
          nxt_cmdOp = bya_op_e'(pwdata[`BYA_CMD_OP_LSB +: 3]);
          nxt_cmdDest = pwdata[`BYA_CMD_DEST_BIT];
          nxt_cmdAddr = pwdata[`BYA_CMD_ADDR_LSB +: 7];
          nxt_cmdLit = pwdata[`BYA_CMD_LIT_LSB +: 8];
          nxt_state = ST_FETCH;
        end
        if (wrFire && (paddr == `BYA_OFF_ACC)) begin
          nxt_acc = pwdata[7:0];
        end
        if (wrFire && (paddr == `BYA_OFF_STAT)) begin
          nxt_borrowOutFlag = pwdata[`BYA_ST_BORROW];
          nxt_nibbleBorrowFlag = pwdata[`BYA_ST_NIBBLE];
          nxt_resultNullFlag = pwdata[`BYA_ST_NULL];
          if (pwdata[`BYA_ST_BADOP]) begin
            nxt_badOp = 1'b0;
          end
        end
      end
      ST_FETCH: begin
        memBus.addr = cmdAddr_ff[FILE_AW-1:0];
        nxt_state = ST_EXEC;
      end
      ST_EXEC: begin
        memBus.addr = cmdAddr_ff[FILE_AW-1:0];
        memBus.wdata = result;
        nxt_state = ST_IDLE;
        case (cmdOp_ff)
          OP_SUB_WITH_BORROW, OP_NIBBLE_EXCHANGE, OP_XOR_FILE: begin
            if (cmdDest_ff) begin
              memBus.we = 1'b1;
            end else begin
              nxt_acc = result;
            end
          end
          OP_XOR_LITERAL: begin
            nxt_acc = result;
          end
          OP_PIN_DIRECTION_LOAD: begin
            case (cmdAddr_ff)
              `BYA_DIR_A: nxt_dirA = acc_ff;
              `BYA_DIR_B: nxt_dirB = acc_ff;
              `BYA_DIR_C: nxt_dirC = acc_ff;
              default: nxt_badOp = 1'b1;
            endcase
          end
          default: begin
            nxt_badOp = 1'b1;
          end
        endcase
        if (cmdOp_ff == OP_SUB_WITH_BORROW) begin
          nxt_borrowOutFlag = ~diff[8];
          nxt_nibbleBorrowFlag = ~diffLow[4];
        end
        if ((cmdOp_ff == OP_SUB_WITH_BORROW) || (cmdOp_ff == OP_XOR_LITERAL) ||
            (cmdOp_ff == OP_XOR_FILE)) begin
          nxt_resultNullFlag = (result == 8'h00);
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      cmdOp_ff <= OP_SUB_WITH_BORROW;
      cmdDest_ff <= 1'b0;
      cmdAddr_ff <= 7'h00;
      cmdLit_ff <= 8'h00;
      acc_ff <= `BYA_ACC_RST;
      borrowOutFlag_ff <= 1'b0;
      nibbleBorrowFlag_ff <= 1'b0;
      resultNullFlag_ff <= 1'b0;
      badOp_ff <= 1'b0;
      dirA_ff <= `BYA_DIR_RST;
      dirB_ff <= `BYA_DIR_RST;
      dirC_ff <= `BYA_DIR_RST;
      rdStep_ff <= 2'h0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      cmdOp_ff <= nxt_cmdOp;
      cmdDest_ff <= nxt_cmdDest;
      cmdAddr_ff <= nxt_cmdAddr;
      cmdLit_ff <= nxt_cmdLit;
      acc_ff <= nxt_acc;
      borrowOutFlag_ff <= nxt_borrowOutFlag;
      nibbleBorrowFlag_ff <= nxt_nibbleBorrowFlag;
      resultNullFlag_ff <= nxt_resultNullFlag;
      badOp_ff <= nxt_badOp;
      dirA_ff <= nxt_dirA;
      dirB_ff <= nxt_dirB;
      dirC_ff <= nxt_dirC;
      rdStep_ff <= nxt_rdStep;
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata = prdata_ff;
  assign portADirection = dirA_ff;
  assign portBDirection = dirB_ff;
  assign portCDirection = dirC_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  logic inExec;
  assign inExec = (state_ff == ST_EXEC);

  a_sub_result: assert property (
    inExec && cmdOp_ff == OP_SUB_WITH_BORROW && !cmdDest_ff |=>
      acc_ff == 8'($past(memBus.rdata) - $past(acc_ff) - {7'h00, ~$past(borrowOutFlag_ff)}))
    else $error("sub with borrow result wrong");

  a_op_latency: assert property (
    wrFire && paddr == `BYA_OFF_CMD |=> state_ff == ST_FETCH ##1 inExec ##1 !busy)
    else $error("operation sequence wrong");

  a_sub_borrow: assert property (
    inExec && cmdOp_ff == OP_SUB_WITH_BORROW |=>
      borrowOutFlag_ff == (9'($past(memBus.rdata)) >=
        9'($past(acc_ff)) + 9'(!$past(borrowOutFlag_ff))))
    else $error("borrow flag wrong");

  a_swap_flags: assert property (
    inExec && cmdOp_ff == OP_NIBBLE_EXCHANGE |=>
      $stable({borrowOutFlag_ff, nibbleBorrowFlag_ff, resultNullFlag_ff}) &&
      (cmdDest_ff || acc_ff == {$past(memBus.rdata[3:0]), $past(memBus.rdata[7:4])}))
    else $error("nibble exchange wrong");

  a_dir_load: assert property (
    inExec && cmdOp_ff == OP_PIN_DIRECTION_LOAD && cmdAddr_ff == `BYA_DIR_B |=>
      portBDirection == $past(acc_ff) && $stable(resultNullFlag_ff) && $stable(portADirection))
    else $error("direction load wrong");

  a_xorl_flags: assert property (
    inExec && cmdOp_ff == OP_XOR_LITERAL |=>
      acc_ff == ($past(acc_ff) ^ $past(cmdLit_ff)) && $stable(borrowOutFlag_ff) &&
      $stable(nibbleBorrowFlag_ff))
    else $error("xor literal wrong");

  a_xorf_file: assert property (
    inExec && cmdOp_ff == OP_XOR_FILE && cmdDest_ff |->
      memBus.we && memBus.wdata == (acc_ff ^ memBus.rdata) ##1 $stable(acc_ff))
    else $error("xor file write wrong");

  a_null_flag: assert property (
    inExec && !cmdDest_ff && (cmdOp_ff == OP_XOR_LITERAL || cmdOp_ff == OP_XOR_FILE ||
      cmdOp_ff == OP_SUB_WITH_BORROW) |=> resultNullFlag_ff == (acc_ff == 8'h00))
    else $error("null flag wrong");

  c_sub_zero: cover property (inExec && cmdOp_ff == OP_SUB_WITH_BORROW ##1 resultNullFlag_ff);
  c_swap_file: cover property (inExec && cmdOp_ff == OP_NIBBLE_EXCHANGE && cmdDest_ff);
  c_dir_c: cover property (inExec && cmdOp_ff == OP_PIN_DIRECTION_LOAD &&
    cmdAddr_ff == `BYA_DIR_C);
  c_file_read: cover property (access && !pwrite && isFile && pready);
endmodule : bya_alu_top

// >>> logic/bya_regs.svh
// Purpose: Register offsets, field positions and reset values of the byte ALU
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef BYA_REGS_SVH
`define BYA_REGS_SVH
`define BYA_OFF_CMD 12'h000
`define BYA_OFF_ACC 12'h004
`define BYA_OFF_STAT 12'h008
`define BYA_OFF_DIR 12'h00C
// File window: 0x200..0x3FC, one file register per word
`define BYA_FILE_SEL 3'h1
`define BYA_CMD_OP_LSB 0
`define BYA_CMD_DEST_BIT 3
`define BYA_CMD_ADDR_LSB 4
`define BYA_CMD_LIT_LSB 16
`define BYA_ST_BORROW 0
`define BYA_ST_NIBBLE 1
`define BYA_ST_NULL 2
`define BYA_ST_BUSY 8
`define BYA_ST_BADOP 9
`define BYA_ACC_RST 8'h00
`define BYA_DIR_RST 8'hFF
`define BYA_DIR_A 7'h05
`define BYA_DIR_B 7'h06
`define BYA_DIR_C 7'h07
`define BYA_RD_STEPS 2'h2
`endif

// >>> logic/bya_pkg.sv
// Purpose: Types shared by the byte ALU files
// Assumes: Nothing
// Notes: Opcode values are the command field encoding
package bya_pkg;
  typedef enum logic [2:0] {
    OP_SUB_WITH_BORROW = 3'h0,
    OP_NIBBLE_EXCHANGE = 3'h1,
    OP_PIN_DIRECTION_LOAD = 3'h2,
    OP_XOR_LITERAL = 3'h3,
    OP_XOR_FILE = 3'h4
  } bya_op_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FETCH = 2'h1,
    ST_EXEC = 2'h3
  } bya_state_e;
  typedef logic [7:0] bya_byte_t;
endpackage : bya_pkg

// >>> logic/bya_mem_if.sv
// Purpose: Port between the ALU control and the file register memory
// Assumes: Single port, registered read data
// Notes: Read data follow the address by one clock
`timescale 1ns/100ps
interface bya_mem_if #(parameter int AW = 7, parameter int DW = 8);
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface : bya_mem_if

// >>> logic/bya_file_mem.sv
// Purpose: File register storage for the byte ALU
// Assumes: One access per clock, write has no read-back in the same cycle
// Notes: Array content is not reset, only the read register is
`timescale 1ns/100ps
module bya_file_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clock, // Core clock
  input wire logic rstn, // Async reset, active low
  bya_mem_if.mem bus // Memory port
);
  logic [DW-1:0] store [0:(1<<AW)-1];
  logic [DW-1:0] rdata_ff;
  logic [DW-1:0] nxt_rdata;

  always_comb begin
    nxt_rdata = store[bus.addr];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Storage kept free of reset so it maps onto plain RAM
  always_ff @(posedge clock) begin
    if (bus.we) begin
      store[bus.addr] <= bus.wdata;
    end
  end

  assign bus.rdata = rdata_ff;
endmodule : bya_file_mem

// >>> bench/bya_apb_host.sv
// Purpose: APB master standing in for the core that programs the byte ALU
// Assumes: One transfer at a time, signals change right after a rising edge
// Notes: Waits for pready without bound; the bench timeout cuts a hang
`timescale 1ns/100ps
module bya_apb_host (
  input wire logic clock, // Core clock
  input wire logic pready, // Slave ready
  input wire logic [31:0] prdata, // Read data
  input wire logic pslverr, // Slave error
  output logic psel, // Select
  output logic penable, // Access phase
  output logic pwrite, // Direction
  output logic [11:0] paddr, // Byte address
  output logic [31:0] pwdata // Write data
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Request held until the edge that samples pready high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : bya_apb_host

// >>> bench/byte_alu_op_subset_bench.sv
// Purpose: Self-checking bench for the byte ALU datapath
// Assumes: File registers written before they are read
// Notes: Expectations worked out by hand from the operation semantics
`timescale 1ns/100ps
`include "bya_regs.svh"
module byte_alu_op_subset_bench;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] dirA, dirB, dirC;
  int errTotal = 0;
  int checked = 0;
  int cycles = 0;
  always #2 clock = ~clock;
  bya_alu_top dut (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .portADirection(dirA), .portBDirection(dirB), .portCDirection(dirC));
  bya_apb_host host (.clock(clock), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    host.xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic expectReg(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, a, 32'h0000_0000, r, e);
    check(r, exp);
  endtask : expectReg
  function automatic logic [11:0] fileAddr(input logic [6:0] n);
    return 12'h200 + {3'h0, n, 2'b00};
  endfunction : fileAddr
  task automatic runOp(input logic [2:0] op, input logic dst, input logic [6:0] f,
                       input logic [7:0] lit);
    wr(`BYA_OFF_CMD, {8'h00, lit, 5'h00, f, dst, op});
  endtask : runOp
  ////////////////////////////////////////////////////////////////////////////
  task automatic testResetMap();
    logic [31:0] r;
    logic e;
    expectReg(`BYA_OFF_ACC, 32'h0000_0000);
    expectReg(`BYA_OFF_STAT, 32'h0000_0000);
    expectReg(`BYA_OFF_DIR, 32'h00FF_FFFF);
    host.xfer(1'b0, 12'h010, 32'h0000_0000, r, e);
    check(r, 32'h0000_0000);
    check({31'h0, e}, 32'h0000_0001);
  endtask : testResetMap
  task automatic testSub();
    fileSet(7'h03, 8'h10);
    wr(`BYA_OFF_ACC, 32'h0000_0001);
    wr(`BYA_OFF_STAT, 32'h0000_0001);
    runOp(3'h0, 1'b0, 7'h03, 8'h00);
    expectReg(`BYA_OFF_ACC, 32'h0000_000F);
    expectReg(`BYA_OFF_STAT, 32'h0000_0001);
    fileSet(7'h04, 8'h05);
    wr(`BYA_OFF_ACC, 32'h0000_0005);
    wr(`BYA_OFF_STAT, 32'h0000_0000);
    runOp(3'h0, 1'b1, 7'h04, 8'h00);
    expectReg(fileAddr(7'h04), 32'h0000_00FF);
    expectReg(`BYA_OFF_ACC, 32'h0000_0005);
    expectReg(`BYA_OFF_STAT, 32'h0000_0000);
    fileSet(7'h04, 8'h05);
    wr(`BYA_OFF_STAT, 32'h0000_0001);
    runOp(3'h0, 1'b0, 7'h04, 8'h00);
    expectReg(`BYA_OFF_ACC, 32'h0000_0000);
    expectReg(`BYA_OFF_STAT, 32'h0000_0007);
  endtask : testSub
  task automatic fileSet(input logic [6:0] n, input logic [7:0] v);
    wr(fileAddr(n), {24'h00_0000, v});
  endtask : fileSet
  task automatic testSwap();
    fileSet(7'h05, 8'hA5);
    runOp(3'h1, 1'b1, 7'h05, 8'h00);
    expectReg(fileAddr(7'h05), 32'h0000_005A);
    runOp(3'h1, 1'b0, 7'h05, 8'h00);
    expectReg(`BYA_OFF_ACC, 32'h0000_00A5);
    expectReg(`BYA_OFF_STAT, 32'h0000_0007);
  endtask : testSwap
  // Direction load for operands 5 to 7, others refused
  task automatic testDir();
    for (int i = 5; i <= 7; i++) begin
      wr(`BYA_OFF_ACC, 32'h0000_0011 * (i - 4));
      runOp(3'h2, 1'b0, i[6:0], 8'h00);
    end
    // The last load lands two edges after its command write; the pins are seen one later
    repeat (3) @(posedge clock);
    check({8'h00, dirC, dirB, dirA}, 32'h0033_2211);
    wr(`BYA_OFF_ACC, 32'h0000_0044);
    runOp(3'h2, 1'b0, 7'h04, 8'h00);
    expectReg(`BYA_OFF_DIR, 32'h0033_2211);
    expectReg(`BYA_OFF_STAT, 32'h0000_0207);
    // An opcode outside the five is refused: bad operand bit set, data untouched
    wr(`BYA_OFF_STAT, 32'h0000_0207);
    runOp(3'h5, 1'b0, 7'h05, 8'h00);
    expectReg(`BYA_OFF_STAT, 32'h0000_0207);
    expectReg(`BYA_OFF_ACC, 32'h0000_0044);
  endtask : testDir
  // Literal xor lands in the accumulator only
  task automatic testXorLit();
    wr(`BYA_OFF_STAT, 32'h0000_0203);
    fileSet(7'h00, 8'h99);
    wr(`BYA_OFF_ACC, 32'h0000_003C);
    runOp(3'h3, 1'b1, 7'h00, 8'h3C);
    expectReg(`BYA_OFF_ACC, 32'h0000_0000);
    expectReg(fileAddr(7'h00), 32'h0000_0099);
    expectReg(`BYA_OFF_STAT, 32'h0000_0007);
    runOp(3'h3, 1'b0, 7'h00, 8'hFF);
    expectReg(`BYA_OFF_ACC, 32'h0000_00FF);
    expectReg(`BYA_OFF_STAT, 32'h0000_0003);
  endtask : testXorLit
  // File xor at the top two file addresses, one per destination
  task automatic testXorFile();
    fileSet(7'h7F, 8'h0F);
    wr(`BYA_OFF_ACC, 32'h0000_00F0);
    runOp(3'h4, 1'b1, 7'h7F, 8'h00);
    expectReg(fileAddr(7'h7F), 32'h0000_00FF);
    expectReg(`BYA_OFF_ACC, 32'h0000_00F0);
    fileSet(7'h7E, 8'hF0);
    runOp(3'h4, 1'b0, 7'h7E, 8'h00);
    expectReg(`BYA_OFF_ACC, 32'h0000_0000);
    expectReg(`BYA_OFF_STAT, 32'h0000_0007);
  endtask : testXorFile
  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("compares %0d, mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  // Generous ceiling: the full sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errTotal++;
      results();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    testResetMap();
    testSub();
    testSwap();
    testDir();
    testXorLit();
    testXorFile();
    results();
  end
endmodule : byte_alu_op_subset_bench
